// file: cpr_regs.sv
// chip-level configuration port relocation and test registers
// Operation
// - high config address byte is read/write
// - low byte stores bits 7:1, bit0 zero
// - reserved indices ignore writes, read zero
// - test bit 6 holds keyboard controller reset
// - high byte write moves base immediately
// - bus reset, main POR or a written base of 0x0000 restore address
// - strap selects default address 0x2E or 0x4E
// - logical unit number selects register bank
// - index port write, then data port access
// - unit banks reachable only in config state
`include "cpr_defines.svh"
module cpr_regs #(
  parameter int NUM_LDEV = `CPR_NUM_LDEV
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic vcc_por_n_i,
  input wire logic stby_por_n_i,
  input wire logic strap_i,
  input wire logic cfg_state_i,
  input wire logic idx_wr_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire cpr_pkg::cpr_byte_t wdata_i,
  output cpr_pkg::cpr_byte_t rdata_o,
  output logic rvalid_o,
  output cpr_pkg::cpr_addr_t cfg_base_o,
  output logic kbc_reset_o,
  output cpr_pkg::cpr_byte_t ldev_sel_o,
  output cpr_pkg::cpr_byte_t ldev_idx_o,
  output logic ldev_wr_o,
  output logic ldev_rd_o,
  output cpr_pkg::cpr_byte_t ldev_wdata_o
);
  import cpr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // strap input synchroniser; first stage feeds only the second
  logic strap_s1_ff, strap_s2_ff;
  always_ff @(posedge clk_sys_i) begin
    strap_s1_ff <= strap_i;
    strap_s2_ff <= strap_s1_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  // address reset: host bus reset or main-supply power-on only
  logic addr_rst;
  assign addr_rst = !rst_n_i || !vcc_por_n_i;
  // test registers reset on either power-on, not on bus reset
  logic test_rst;
  assign test_rst = !vcc_por_n_i || !stby_por_n_i;

  cpr_byte_t index_ff, nxt_index;
  cpr_byte_t ldn_ff, nxt_ldn;
  cpr_byte_t addr_lo_ff, nxt_addr_lo;
  cpr_byte_t addr_hi_ff, nxt_addr_hi;
  cpr_addr_t base_ff, nxt_base;
  cpr_byte_t test_ff [6];
  cpr_byte_t nxt_test [6];
  cpr_byte_t rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic ld_wr_ff, nxt_ld_wr, ld_rd_ff, nxt_ld_rd;
  cpr_byte_t ld_wdata_ff, nxt_ld_wdata;
  cpr_addr_t def_addr;
  logic in_ldev, ld_ok, wr_hit, rd_hit, hi_wr_take;

  // default base follows the synchronised strap
  assign def_addr = strap_s2_ff ? `CPR_DEF_ADDR_STRAP1
                                : `CPR_DEF_ADDR_STRAP0;
  assign in_ldev = (index_ff >= `CPR_IDX_LDEV_BASE);
  // unit banks only in config state and for a real unit number
  assign ld_ok = in_ldev && cfg_state_i &&
                 (ldn_ff < 8'(NUM_LDEV));
  assign wr_hit = data_wr_i && cfg_state_i;
  assign rd_hit = data_rd_i && cfg_state_i;
  // outside address reset and the strap reload, a taken high-byte write is the only event allowed to move the base
  assign hi_wr_take = clk_en_i && wr_hit && index_ff == `CPR_IDX_ADDR_HI;

  ////////////////////////////////////////////////////////////////////////
  // next-state for index, address, test and unit-forwarding state
  always_comb begin
    nxt_index = index_ff;
    nxt_ldn = ldn_ff;
    nxt_addr_lo = addr_lo_ff;
    nxt_addr_hi = addr_hi_ff;
    nxt_base = base_ff;
    for (int ti = 0; ti < 6; ti++) begin
      nxt_test[ti] = test_ff[ti];
    end
    nxt_rdata = rdata_ff;
    nxt_rvalid = 1'b0;
    nxt_ld_wr = 1'b0;
    nxt_ld_rd = 1'b0;
    nxt_ld_wdata = ld_wdata_ff;
    if (idx_wr_i) begin
      nxt_index = wdata_i;
    end
    if (wr_hit) begin
      unique case (index_ff)
        `CPR_IDX_LDN: nxt_ldn = wdata_i;
        `CPR_IDX_ADDR_LO: nxt_addr_lo = {wdata_i[7:1], 1'b0};
        `CPR_IDX_ADDR_HI: begin
          nxt_addr_hi = wdata_i;
          // high byte write commits the new base at once
          nxt_base = {wdata_i, addr_lo_ff};
        end
        `CPR_IDX_TEST_A: nxt_test[0] = wdata_i;
        `CPR_IDX_TEST_B: nxt_test[1] = wdata_i;
        `CPR_IDX_TEST_KBC: nxt_test[2] = wdata_i;
        `CPR_IDX_TEST_C: nxt_test[3] = wdata_i;
        `CPR_IDX_TEST_D: nxt_test[4] = wdata_i;
        `CPR_IDX_TEST_E: nxt_test[5] = wdata_i;
        default: begin
          // reserved chip indices fall here and are dropped
          if (ld_ok) begin
            nxt_ld_wr = 1'b1;
            nxt_ld_wdata = wdata_i;
          end
        end
      endcase
    end
    if (rd_hit) begin
      nxt_rvalid = 1'b1;
      unique case (index_ff)
        `CPR_IDX_LDN: nxt_rdata = ldn_ff;
        `CPR_IDX_ADDR_LO: nxt_rdata = addr_lo_ff;
        `CPR_IDX_ADDR_HI: nxt_rdata = addr_hi_ff;
        `CPR_IDX_RSVD_A, `CPR_IDX_RSVD_B: nxt_rdata = 8'h00;
        `CPR_IDX_TEST_A: nxt_rdata = test_ff[0];
        `CPR_IDX_TEST_B: nxt_rdata = test_ff[1];
        `CPR_IDX_TEST_KBC: nxt_rdata = test_ff[2];
        `CPR_IDX_TEST_C: nxt_rdata = test_ff[3];
        `CPR_IDX_TEST_D: nxt_rdata = test_ff[4];
        `CPR_IDX_TEST_E: nxt_rdata = test_ff[5];
        default: begin
          nxt_rdata = 8'h00;
          nxt_ld_rd = ld_ok;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address registers: survive standby power-on, cleared by bus reset or main power-on
  always_ff @(posedge clk_sys_i) begin
    if (addr_rst) begin
      addr_lo_ff <= 8'h00;
      addr_hi_ff <= 8'h00;
      base_ff <= 16'h0000;
    end else if (base_ff == 16'h0000) begin
      // first cycle after release loads the strap default, whatever the clock enable
      addr_lo_ff <= def_addr[7:0];
      addr_hi_ff <= def_addr[15:8];
      base_ff <= def_addr;
    end else if (clk_en_i) begin
      addr_lo_ff <= nxt_addr_lo;
      addr_hi_ff <= nxt_addr_hi;
      base_ff <= nxt_base;
    end
  end

  // test registers reset by either power-on only
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < 6; i++) begin
      if (test_rst) begin
        test_ff[i] <= `CPR_RST_TEST;
      end else if (clk_en_i) begin
        test_ff[i] <= nxt_test[i];
      end
    end
  end

  // index, unit number and access outputs
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      index_ff <= 8'h00;
      ldn_ff <= `CPR_RST_LDN;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      ld_wr_ff <= 1'b0;
      ld_rd_ff <= 1'b0;
      ld_wdata_ff <= 8'h00;
    end else if (clk_en_i) begin
      index_ff <= nxt_index;
      ldn_ff <= nxt_ldn;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      ld_wr_ff <= nxt_ld_wr;
      ld_rd_ff <= nxt_ld_rd;
      ld_wdata_ff <= nxt_ld_wdata;
    end
  end

  assign rdata_o = rdata_ff;
  assign rvalid_o = rvalid_ff;
  assign cfg_base_o = base_ff;
  assign kbc_reset_o = test_ff[2][`CPR_KBC_RST_BIT];
  assign ldev_sel_o = ldn_ff;
  assign ldev_idx_o = index_ff;
  assign ldev_wr_o = ld_wr_ff;
  assign ldev_rd_o = ld_rd_ff;
  assign ldev_wdata_o = ld_wdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_hi_write;
    clk_en_i && wr_hit && index_ff == `CPR_IDX_ADDR_HI;
  endsequence
  property p_base_move;
    @(posedge clk_sys_i) disable iff (addr_rst)
    s_hi_write ##1 1'b1 |-> cfg_base_o == {addr_hi_ff, addr_lo_ff};
  endproperty
  a_base_move: assert property (p_base_move)
    else $error("base did not move on high byte write");
  property p_lo_even;
    @(posedge clk_sys_i) disable iff (addr_rst) !addr_lo_ff[0];
  endproperty
  a_lo_even: assert property (p_lo_even)
    else $error("low address bit zero set");
  property p_hi_store;
    @(posedge clk_sys_i) disable iff (addr_rst || base_ff == 16'h0000)
    s_hi_write |=> addr_hi_ff == $past(wdata_i);
  endproperty
  a_hi_store: assert property (p_hi_store)
    else $error("high address byte not stored");
  property p_rsvd_zero;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    clk_en_i && rd_hit && (index_ff == `CPR_IDX_RSVD_A ||
      index_ff == `CPR_IDX_RSVD_B) |=> rdata_o == 8'h00 && rvalid_o;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved index read nonzero");
  property p_kbc;
    @(posedge clk_sys_i) disable iff (test_rst)
    clk_en_i && wr_hit && index_ff == `CPR_IDX_TEST_KBC
      |=> kbc_reset_o == $past(wdata_i[6]);
  endproperty
  a_kbc: assert property (p_kbc)
    else $error("keyboard reset bit not applied");
  property p_keep_base;
    @(posedge clk_sys_i) disable iff (addr_rst)
    !hi_wr_take && base_ff != 16'h0000 |=> $stable(cfg_base_o);
  endproperty
  a_keep_base: assert property (p_keep_base)
    else $error("base changed without high byte write");
  property p_ldev_gate;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ldev_wr_o || ldev_rd_o |-> $past(cfg_state_i) && $past(in_ldev);
  endproperty
  a_ldev_gate: assert property (p_ldev_gate)
    else $error("unit bank reached outside config state");
  property p_idx;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    clk_en_i && idx_wr_i |=> ldev_idx_o == $past(wdata_i);
  endproperty
  a_idx: assert property (p_idx)
    else $error("index port write not taken");
  sequence s_lo_write;
    clk_en_i && wr_hit && index_ff == `CPR_IDX_ADDR_LO;
  endsequence
  property p_lo_store;
    @(posedge clk_sys_i) disable iff (addr_rst || base_ff == 16'h0000)
    s_lo_write |=> addr_lo_ff == {$past(wdata_i[7:1]), 1'b0};
  endproperty
  a_lo_store: assert property (p_lo_store)
    else $error("low address byte not stored even");
  // a dropped write must leave the base and unit number as they were and forward no unit write
  sequence s_rsvd_write;
    clk_en_i && wr_hit && (index_ff == `CPR_IDX_RSVD_A ||
      index_ff == `CPR_IDX_RSVD_B);
  endsequence
  property p_rsvd_keep;
    @(posedge clk_sys_i) disable iff (addr_rst || base_ff == 16'h0000)
    s_rsvd_write |=> $stable(cfg_base_o) && $stable(ldev_sel_o) &&
      !ldev_wr_o;
  endproperty
  a_rsvd_keep: assert property (p_rsvd_keep)
    else $error("reserved index write changed state");
  property p_rd_answer;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    clk_en_i && rd_hit |=> rvalid_o;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("data port read gave no answer");
  // outside the config state the data port is deaf to reads and writes
  property p_refuse;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    clk_en_i && !cfg_state_i |=> !rvalid_o && !ldev_wr_o && !ldev_rd_o;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("data port answered outside config state");
  property p_ldn_bank;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ldev_wr_o || ldev_rd_o |-> ldev_sel_o < 8'(NUM_LDEV);
  endproperty
  a_ldn_bank: assert property (p_ldn_bank)
    else $error("unit access forwarded for missing unit");
  // a cleared base is refilled from the strap on the next edge
  property p_strap_default;
    @(posedge clk_sys_i) disable iff (addr_rst)
    base_ff == 16'h0000 |=> cfg_base_o == $past(def_addr);
  endproperty
  a_strap_default: assert property (p_strap_default)
    else $error("default base does not follow strap");
endmodule : cpr_regs

// file: cpr_defines.svh
// constants for the configuration port relocation register bank
`ifndef CPR_DEFINES_SVH
`define CPR_DEFINES_SVH
`define CPR_IDX_LDN 8'h07
`define CPR_IDX_ADDR_LO 8'h26
`define CPR_IDX_ADDR_HI 8'h27
`define CPR_IDX_RSVD_A 8'h28
`define CPR_IDX_RSVD_B 8'h29
`define CPR_IDX_TEST_A 8'h2A
`define CPR_IDX_TEST_B 8'h2B
`define CPR_IDX_TEST_KBC 8'h2C
`define CPR_IDX_TEST_C 8'h2D
`define CPR_IDX_TEST_D 8'h2E
`define CPR_IDX_TEST_E 8'h2F
`define CPR_IDX_LDEV_BASE 8'h30
`define CPR_DEF_ADDR_STRAP0 16'h002E
`define CPR_DEF_ADDR_STRAP1 16'h004E
`define CPR_RST_TEST 8'h00
`define CPR_RST_LDN 8'h00
`define CPR_KBC_RST_BIT 6
`define CPR_NUM_LDEV 9
`endif

// file: cpr_pkg.sv
// types shared by the configuration port relocation register bank
package cpr_pkg;
  typedef logic [7:0] cpr_byte_t;
  typedef logic [15:0] cpr_addr_t;
endpackage : cpr_pkg

// file: cpr_host.sv
// host model driving the configuration index and data ports
`include "cpr_defines.svh"
module cpr_host (
  input wire logic clk_sys_i,
  output logic idx_wr_o,
  output logic data_wr_o,
  output logic data_rd_o,
  output cpr_pkg::cpr_byte_t wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import cpr_pkg::*;
  // idle bus at time zero
  initial begin
    idx_wr_o = 1'b0;
    data_wr_o = 1'b0;
    data_rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // one bus cycle, launched just after the edge
  task automatic step(input logic i, input logic w, input logic r,
      input cpr_byte_t d);
    @(posedge clk_sys_i);
    #1;
    idx_wr_o = i;
    data_wr_o = w;
    data_rd_o = r;
    wdata_o = d;
  endtask : step
  // idle data is inverted so a stale byte is never mistaken for fresh
  task automatic wr(input cpr_byte_t idx, input cpr_byte_t d);
    step(1'b1, 1'b0, 1'b0, idx);
    step(1'b0, 1'b1, 1'b0, d);
    step(1'b0, 1'b0, 1'b0, ~d);
  endtask : wr
  task automatic rd(input cpr_byte_t idx);
    step(1'b1, 1'b0, 1'b0, idx);
    step(1'b0, 1'b0, 1'b1, ~idx);
    step(1'b0, 1'b0, 1'b0, idx);
  endtask : rd
endmodule : cpr_host

// file: cpr_regs_test.sv
// self-checking bench for the configuration port relocation registers
`include "cpr_defines.svh"
module cpr_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cpr_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, vcc_por_n_i = 1'b0;
  logic stby_por_n_i = 1'b0, strap_i = 1'b0, cfg_state_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic idx_wr, data_wr, data_rd, rvalid_o, kbc_reset_o, ldev_wr_o;
  logic ldev_rd_o;
  cpr_byte_t wdata, rdata_o, ldev_sel_o, ldev_idx_o, ldev_wdata_o;
  cpr_addr_t cfg_base_o, a, prev;
  cpr_byte_t exp_q[$];
  int errors = 0, tests_run = 0, wr_seen = 0, rd_seen = 0;
  logic [31:0] seed;
  always #50 clk_sys_i = ~clk_sys_i;
  cpr_regs cpr_regs_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i), .vcc_por_n_i(vcc_por_n_i),
    .stby_por_n_i(stby_por_n_i),
    .strap_i(strap_i), .cfg_state_i(cfg_state_i), .idx_wr_i(idx_wr),
    .data_wr_i(data_wr), .data_rd_i(data_rd), .wdata_i(wdata),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .cfg_base_o(cfg_base_o),
    .kbc_reset_o(kbc_reset_o), .ldev_sel_o(ldev_sel_o),
    .ldev_idx_o(ldev_idx_o), .ldev_wr_o(ldev_wr_o), .ldev_rd_o(ldev_rd_o),
    .ldev_wdata_o(ldev_wdata_o));
  cpr_host cpr_host_i (.clk_sys_i(clk_sys_i), .idx_wr_o(idx_wr),
    .data_wr_o(data_wr), .data_rd_o(data_rd), .wdata_o(wdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdx(input cpr_byte_t idx, input cpr_byte_t exp);
    exp_q.push_back(exp);
    cpr_host_i.rd(idx);
  endtask : rdx
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic end_sim();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////
  // an answer with no read pending is a mismatch by itself
  always @(negedge clk_sys_i) begin
    if (rvalid_o === 1'b1) begin
      if (exp_q.size() == 0)
        check(rdata_o, 16'hFFFF);
      else
        check(rdata_o, exp_q.pop_front());
    end
    if (ldev_wr_o === 1'b1)
      wr_seen++;
    if (ldev_rd_o === 1'b1)
      rd_seen++;
  end
  // watchdog so a hung run still reaches the verdict
  initial begin
    cyc(4000);
    errors++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h2F47819F;
    cyc(5);
    rst_n_i = 1'b1;
    vcc_por_n_i = 1'b1;
    stby_por_n_i = 1'b1;
    cyc(3);
    check(cfg_base_o, `CPR_DEF_ADDR_STRAP0);
    cfg_state_i = 1'b1;
    prev = `CPR_DEF_ADDR_STRAP0;
    // relocate to random even addresses, low byte first
    for (int k = 0; k < 3; k++) begin
      a = 16'($random(seed));
      a[15] = 1'b1;
      a[0] = 1'b0;
      cpr_host_i.wr(`CPR_IDX_ADDR_LO, a[7:0]);
      check(cfg_base_o, prev);
      cpr_host_i.wr(`CPR_IDX_ADDR_HI, a[15:8]);
      check(cfg_base_o, a);
      rdx(`CPR_IDX_ADDR_LO, a[7:0]);
      rdx(`CPR_IDX_ADDR_HI, a[15:8]);
      prev = a;
    end
    for (int k = 0; k < 2; k++) begin
      cpr_host_i.wr(8'(`CPR_IDX_RSVD_A + k), 8'hFF);
      rdx(8'(`CPR_IDX_RSVD_A + k), 8'h00);
    end
    cpr_host_i.wr(`CPR_IDX_TEST_KBC, 8'h40);
    check(kbc_reset_o, 1'b1);
    rdx(`CPR_IDX_TEST_KBC, 8'h40);
    cpr_host_i.wr(`CPR_IDX_TEST_KBC, 8'h00);
    check(kbc_reset_o, 1'b0);
    for (int k = 0; k < 6; k++)
      rdx(8'(`CPR_IDX_TEST_A + k), `CPR_RST_TEST);
    // unit bank forwarding inside and outside the config state
    cpr_host_i.wr(`CPR_IDX_LDN, 8'h03);
    check(ldev_sel_o, 8'h03);
    cpr_host_i.wr(`CPR_IDX_LDEV_BASE, 8'hA5);
    check(ldev_idx_o, `CPR_IDX_LDEV_BASE);
    check(ldev_wdata_o, 8'hA5);
    // unit reads are forwarded; this block itself answers zero
    rdx(`CPR_IDX_LDEV_BASE, 8'h00);
    cfg_state_i = 1'b0;
    cpr_host_i.wr(`CPR_IDX_LDEV_BASE, 8'h5A);
    cpr_host_i.rd(`CPR_IDX_LDEV_BASE);
    cpr_host_i.wr(`CPR_IDX_LDN, 8'h05);
    check(ldev_sel_o, 8'h03);
    cfg_state_i = 1'b1;
    cpr_host_i.wr(`CPR_IDX_LDN, 8'h09);
    cpr_host_i.wr(`CPR_IDX_LDEV_BASE, 8'h3C);
    // a frozen clock enable must swallow a whole write
    clk_en_i = 1'b0;
    cpr_host_i.wr(`CPR_IDX_LDN, 8'h02);
    clk_en_i = 1'b1;
    check(ldev_sel_o, 8'h09);
    check(ldev_idx_o, `CPR_IDX_LDEV_BASE);
    cyc(2);
    check(16'(wr_seen), 16'h0001);
    check(16'(rd_seen), 16'h0001);
    // standby reset keeps the base, bus reset restores the strap default
    stby_por_n_i = 1'b0;
    cyc(2);
    stby_por_n_i = 1'b1;
    cyc(3);
    check(cfg_base_o, prev);
    strap_i = 1'b1;
    cyc(4);
    rst_n_i = 1'b0;
    cyc(5);
    rst_n_i = 1'b1;
    cyc(3);
    check(cfg_base_o, `CPR_DEF_ADDR_STRAP1);
    check(16'(exp_q.size()), 16'h0000);
    end_sim();
  end
endmodule : cpr_regs_test
